/* src/icr_pkg.sv */
// icr_pkg: shared constants of the interrupt global control block
// assumes: 32-bit apb data, 12-bit byte addresses, one aligned word each
package icr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL2  = 12'h000; // interrupt_control_two
  localparam logic [11:0] ADDR_STAT   = 12'h004; // sticky event status
  localparam logic [11:0] ADDR_CLEAR  = 12'h008; // write one to clear
  localparam logic [11:0] ADDR_ENABLE = 12'h00C; // event enables

  // ----------------------------------------------------------------
  // interrupt_control_two field layout
  // ----------------------------------------------------------------
  localparam int          GLB_EN_BIT  = 15;
  localparam int          TDIS_BIT    = 14;
  localparam int          TRAP_BIT    = 13;
  localparam int          POL_LSB     = 0;
  localparam int          NUM_EXT     = 3;
  localparam logic [15:0] CTRL2_RESET = 16'h8000;
  localparam logic [15:0] CTRL2_WMASK = 16'hA007; // bit 14 read-only
  localparam logic        GLB_EN_RST  = 1'h1;
  localparam logic        TRAP_RESET  = 1'h0;
  localparam logic [2:0]  POL_RESET   = 3'h0;
  localparam logic [2:0]  EVT_RESET   = 3'h0;

endpackage

/* src/icr_edge_if.sv */
// icr_edge_if: one external interrupt input with its chosen edge
// assumes: the pin is already synchronous to the core clock
`timescale 1ns/1ps
interface icr_edge_if;
  logic pin;   // external interrupt level
  logic pol;   // 1 selects falling edge, 0 rising
  logic pulse; // one-cycle edge event

  modport det (input pin, input pol, output pulse);
  modport ctl (output pin, output pol, input pulse);
endinterface

/* src/icr_edge_det.sv */
// icr_edge_det: edge detector for one external interrupt input
// assumes: clock and synchronous reset copy come from the top module
`timescale 1ns/1ps
module icr_edge_det (
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  // edge channel
  icr_edge_if.det    edge_if
);

  logic prev_r;
  logic prev_nxt;

  // ----------------------------------------------------------------
  // previous level and edge select
  // ----------------------------------------------------------------
  // next value is simply the current pin level
  always_comb begin
    prev_nxt = edge_if.pin;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r <= 1'h0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // falling edge when polarity set, rising edge when clear
  assign edge_if.pulse = edge_if.pol ? (prev_r & ~edge_if.pin)   // RULE_04
                                     : (~prev_r & edge_if.pin);  // RULE_04

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fall_edge;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (edge_if.pol && $fell(edge_if.pin)) |-> edge_if.pulse;
  endproperty
  a_fall_edge: assert property (p_fall_edge) // RULE_04
    else $error("falling edge missed with polarity set");

  property p_rise_edge;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (!edge_if.pol && $rose(edge_if.pin)) |-> edge_if.pulse;
  endproperty
  a_rise_edge: assert property (p_rise_edge) // RULE_04
    else $error("rising edge missed with polarity clear");

endmodule

/* src/icr_top.sv */
// icr_top: global interrupt control register with apb access
// assumes: core drives the timed-disable level, pins are synchronous
//
// Function
// [RULE_01] enable bit 15 resets to one; clear masks interrupts, not traps
// [RULE_02] bit 14 reads one while timed disable is active; resets zero
// [RULE_03] soft trap bit 13 read/write, resets zero, set raises trap
// [RULE_04] bits 2..0 choose edge of external inputs; one selects falling
// [RULE_05] bits 12..3 read zero and ignore writes
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module icr_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // core and pins
  input  wire logic        timed_disable_i,
  input  wire logic [2:0]  ext_irq_i,
  // outputs to the core
  output logic             global_irq_enable_o,
  output logic             soft_trap_o,
  output logic [2:0]       ext_edge_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'h0;
      rst_sync_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // edge detectors, one per external input
  // ----------------------------------------------------------------
  // a net, so each detector lane may drive its own bit
  wire logic [2:0] edge_pulse;
  logic [2:0] ext_irq2_edge_polarity_r; // bits 2..0 of the control word
  icr_edge_if edge_ch [icr_pkg::NUM_EXT] ();

  genvar gi;
  generate
    for (gi = 0; gi < icr_pkg::NUM_EXT; gi++) begin : g_edge
      assign edge_ch[gi].pin  = ext_irq_i[gi];
      assign edge_ch[gi].pol  = ext_irq2_edge_polarity_r[gi];
      assign edge_pulse[gi]   = edge_ch[gi].pulse;
      icr_edge_det u_det (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_sync_r),
        .edge_if (edge_ch[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_sel_ok;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_clear;
  logic hit_enable;

  assign hit_ctrl   = (paddr_i == icr_pkg::ADDR_CTRL2);
  assign hit_stat   = (paddr_i == icr_pkg::ADDR_STAT);
  assign hit_clear  = (paddr_i == icr_pkg::ADDR_CLEAR);
  assign hit_enable = (paddr_i == icr_pkg::ADDR_ENABLE);
  assign rd_sel_ok  = hit_ctrl | hit_stat | hit_clear | hit_enable;
  // zero wait states: every access completes in its first access cycle
  assign pready_o   = 1'h1;
  assign pslverr_o  = psel_i & penable_i & ~rd_sel_ok;
  assign wr_en      = psel_i & penable_i & pwrite_i & rd_sel_ok;

  // ----------------------------------------------------------------
  // control word and interrupt registers
  // ----------------------------------------------------------------
  logic        glb_en_r, glb_en_nxt;
  logic        tdis_r,   tdis_nxt;
  logic        trap_r,  trap_nxt;
  logic [2:0]  pol_nxt;
  logic [2:0]  stat_r,  stat_nxt;
  logic [2:0]  en_r,    en_nxt;
  logic [2:0]  edge_r,  edge_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] ctrl_word;
  logic [15:0] wmasked;

  // unimplemented bits stay zero in the readback word
  always_comb begin
    ctrl_word                   = 16'h0000;                  // RULE_05
    ctrl_word[icr_pkg::GLB_EN_BIT] = glb_en_r;
    ctrl_word[icr_pkg::TDIS_BIT]   = tdis_r;
    ctrl_word[icr_pkg::TRAP_BIT] = trap_r;
    ctrl_word[icr_pkg::POL_LSB +: icr_pkg::NUM_EXT] =
      ext_irq2_edge_polarity_r;
  end

  assign wmasked = pwdata_i[15:0] & icr_pkg::CTRL2_WMASK;    // RULE_05

  // next-state for all software-visible state
  always_comb begin
    glb_en_nxt = glb_en_r;
    trap_nxt  = trap_r;
    pol_nxt   = ext_irq2_edge_polarity_r;
    en_nxt    = en_r;
    tdis_nxt  = timed_disable_i;                              // RULE_02
    edge_nxt  = edge_pulse;
    stat_nxt  = stat_r;
    rdata_nxt = rdata_r;
    if (wr_en && hit_ctrl) begin
      glb_en_nxt = wmasked[icr_pkg::GLB_EN_BIT];              // RULE_01
      trap_nxt = wmasked[icr_pkg::TRAP_BIT];                  // RULE_03
      pol_nxt  = wmasked[icr_pkg::POL_LSB +: icr_pkg::NUM_EXT]; // RULE_04
    end
    if (wr_en && hit_enable) begin
      en_nxt = pwdata_i[2:0];
    end
    if (wr_en && hit_clear) begin
      stat_nxt = stat_nxt & ~pwdata_i[2:0];
    end
    // set after clear so a same-cycle event is never lost
    stat_nxt = stat_nxt | edge_pulse;
    if (psel_i && !penable_i && !pwrite_i) begin
      rdata_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
        rdata_nxt[15:0] = ctrl_word;                          // RULE_05
      end else if (hit_stat) begin
        rdata_nxt[2:0] = stat_r | edge_pulse;
      end else if (hit_enable) begin
        rdata_nxt[2:0] = en_r;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      glb_en_r                 <= icr_pkg::GLB_EN_RST;        // RULE_01
      tdis_r                   <= 1'h0;                       // RULE_02
      trap_r                   <= icr_pkg::TRAP_RESET;        // RULE_03
      ext_irq2_edge_polarity_r <= icr_pkg::POL_RESET;         // RULE_04
      stat_r                   <= icr_pkg::EVT_RESET;
      en_r                     <= icr_pkg::EVT_RESET;
      edge_r                   <= icr_pkg::EVT_RESET;
      rdata_r                  <= 32'h0000_0000;
    end else begin
      glb_en_r                 <= glb_en_nxt;
      tdis_r                   <= tdis_nxt;
      trap_r                   <= trap_nxt;
      ext_irq2_edge_polarity_r <= pol_nxt;
      stat_r                   <= stat_nxt;
      en_r                     <= en_nxt;
      edge_r                   <= edge_nxt;
      rdata_r                  <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // masking by the global enable never touches the trap path
  assign irq_o               = glb_en_r & |(stat_r & en_r);   // RULE_01
  assign soft_trap_o         = trap_r;                        // RULE_03
  assign global_irq_enable_o = glb_en_r;
  assign ext_edge_o          = edge_r;
  assign prdata_o            = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ctrl_write;
    psel_i && penable_i && pwrite_i && hit_ctrl;
  endsequence

  sequence s_ctrl_read;
    psel_i && !penable_i && !pwrite_i && hit_ctrl;
  endsequence

  property p_glb_en_mask;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      !glb_en_r |-> !irq_o;
  endproperty
  a_glb_en_mask: assert property (p_glb_en_mask) // RULE_01
    else $error("interrupt raised while global enable clear");

  property p_glb_en_write;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      s_ctrl_write |=> (glb_en_r == $past(pwdata_i[icr_pkg::GLB_EN_BIT]));
  endproperty
  a_glb_en_write: assert property (p_glb_en_write) // RULE_01
    else $error("global enable did not take written value");

  property p_tdis_track;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      s_ctrl_read ##1 1'b1 |->
        (prdata_o[icr_pkg::TDIS_BIT] == $past(tdis_r, 1));
  endproperty
  a_tdis_track: assert property (p_tdis_track) // RULE_02
    else $error("timed disable bit misread");

  property p_trap_unmasked;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      (s_ctrl_write ##0 pwdata_i[13]) |=> soft_trap_o [*1];
  endproperty
  a_trap_unmasked: assert property (p_trap_unmasked) // RULE_03
    else $error("soft trap not raised after write");

  property p_pol_write;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      s_ctrl_write |=> (ext_irq2_edge_polarity_r == $past(pwdata_i[2:0]));
  endproperty
  a_pol_write: assert property (p_pol_write) // RULE_04
    else $error("polarity bits did not take written value");

  property p_unimpl_zero;
    @(posedge mclk_i) disable iff (!rst_sync_r)
      s_ctrl_read |=> (prdata_o[31:16] == 16'h0000)
                      && (prdata_o[12:3] == 10'h000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // RULE_05
    else $error("unimplemented bits read nonzero");

endmodule

/* tb/interrupt_global_control_reg_bench.sv */
// interrupt_global_control_reg_bench: self-checking bench for icr_top
// assumes: apb master, pins and timed-disable level driven from here
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin \
  err_total++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end end
module interrupt_global_control_reg_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk_i          = 1'b0;
  logic        rst_b_i         = 1'b0;
  logic        psel_i          = 1'b0;
  logic        penable_i       = 1'b0;
  logic        pwrite_i        = 1'b0;
  logic [11:0] paddr_i         = 12'h000;
  logic [31:0] pwdata_i        = 32'h0;
  logic        timed_disable_i = 1'b0;
  logic [2:0]  ext_irq_i       = 3'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        global_irq_enable_o;
  logic        soft_trap_o;
  logic [2:0]  ext_edge_o;
  logic        irq_o;
  int          err_total = 0;
  int          checked   = 0;
  int          seed      = 71980;
  logic [32:0] exp_q[$];   // oldest expected read: {slverr, data}
  logic [32:0] note;
  logic [31:0] d;
  logic [31:0] td;
  logic [2:0]  edge_seen = 3'h0; // last nonzero event output
  int          edge_n    = 0;    // event pulses seen so far
  int          base;

  icr_top i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .timed_disable_i(timed_disable_i),
    .ext_irq_i(ext_irq_i), .global_irq_enable_o(global_irq_enable_o),
    .soft_trap_o(soft_trap_o), .ext_edge_o(ext_edge_o), .irq_o(irq_o));

  // 40 MHz core clock
  always #12.5 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // apb master tasks
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // holds the request until pready is seen; trailing edge keeps psel
  // from being driven twice in one step on back-to-back calls
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                    input logic er);
    exp_q.push_back({er, ex});
    apb(1'b0, a, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // read monitor: compares each completed read with the oldest note
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      note = exp_q.pop_front();
      `CHK("prdata", prdata_o, note[31:0])
      `CHK("pslverr", pslverr_o, note[32])
    end
  end

  // counts event pulses; a pulse stands for one cycle only
  always @(posedge mclk_i) begin
    if (ext_edge_o !== 3'h0) begin
      edge_seen <= ext_edge_o;
      edge_n    <= edge_n + 1;
    end
  end

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  initial begin
    #(25ns * 20000);
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(16);
    rst_b_i <= 1'b1;
    idle(3);
    rd(icr_pkg::ADDR_CTRL2, 32'h0000_8000, 1'b0);
    `CHK("global enable", global_irq_enable_o, 1'b1)
    `CHK("trap", soft_trap_o, 1'b0)
    $display("test reset done");
    // random control words with a random timed-disable level
    for (int i = 0; i < 8; i++) begin
      d  = $random(seed);
      td = $random(seed);
      timed_disable_i <= td[0];
      wr(icr_pkg::ADDR_CTRL2, d);
      idle(1);
      rd(icr_pkg::ADDR_CTRL2,
         (d & 32'h0000_A007) | {td[0], 14'h0}, 1'b0);
      `CHK("global enable", global_irq_enable_o, d[15])
      `CHK("trap", soft_trap_o, d[13])
    end
    timed_disable_i <= 1'b0;
    $display("test control word done");
    // each input, both polarities: chosen edge sets, other edge does not
    for (int n = 0; n < 3; n++) begin
      for (int p = 0; p < 2; p++) begin
        ext_irq_i[n] <= p[0];
        wr(icr_pkg::ADDR_CTRL2, 32'h8000 | (p << n));
        wr(icr_pkg::ADDR_ENABLE, 32'h1 << n);
        idle(2);
        wr(icr_pkg::ADDR_CLEAR, 32'h7);
        base = edge_n;
        ext_irq_i[n] <= ~p[0];
        idle(3);
        `CHK("irq", irq_o, 1'b1)
        `CHK("edge", edge_seen, 3'h1 << n)
        `CHK("edge count", edge_n - base, 1)
        rd(icr_pkg::ADDR_STAT, 32'h1 << n, 1'b0);
        wr(icr_pkg::ADDR_CLEAR, 32'h7);
        base = edge_n;
        ext_irq_i[n] <= p[0];
        idle(3);
        `CHK("edge count", edge_n - base, 0)
        rd(icr_pkg::ADDR_STAT, 32'h0, 1'b0);
        `CHK("irq", irq_o, 1'b0)
      end
    end
    $display("test edge polarity done");
    // global enable masks the request without losing the event
    wr(icr_pkg::ADDR_CTRL2, 32'h0);
    wr(icr_pkg::ADDR_ENABLE, 32'h1);
    ext_irq_i[0] <= 1'b0;
    idle(2);
    wr(icr_pkg::ADDR_CLEAR, 32'h7);
    ext_irq_i[0] <= 1'b1;
    idle(3);
    `CHK("irq", irq_o, 1'b0)
    rd(icr_pkg::ADDR_STAT, 32'h1, 1'b0);
    wr(icr_pkg::ADDR_CTRL2, 32'h8000);
    idle(1);
    `CHK("irq", irq_o, 1'b1)
    wr(icr_pkg::ADDR_CLEAR, 32'h1);
    idle(1);
    `CHK("irq", irq_o, 1'b0)
    $display("test global mask done");
    // unmapped address refused; clear register reads zero
    wr(icr_pkg::ADDR_CTRL2, 32'h2005);
    rd(12'h010, 32'h0, 1'b1);
    wr(12'h010, 32'hFFFF_FFFF);
    rd(icr_pkg::ADDR_CTRL2, 32'h0000_2005, 1'b0);
    rd(icr_pkg::ADDR_CLEAR, 32'h0, 1'b0);
    rd(icr_pkg::ADDR_ENABLE, 32'h1, 1'b0);
    $display("test refusal done");
    stop_test();
  end
endmodule
